// ==== rtl/pss_sequencer.sv ====
// Purpose: power sequencing and protection responses of a camera power controller
// Assumes: all inputs synchronous to CLK; analog monitors arrive as digital levels
// Notes:   control register defaults bring every channel up with no software present
//
// The implementer's own choices: the address map and the Wishbone register port.

module pss_sequencer #(
    parameter int BACKUP_DELAY_US    = pss_pkg::BACKUP_DELAY_US,
    parameter int USB_DELAY_US       = pss_pkg::USB_DELAY_US,
    parameter int SETTLE_DELAY_US    = pss_pkg::SETTLE_DELAY_US,
    parameter int PWM_ENTRY_DELAY_US = pss_pkg::PWM_ENTRY_DELAY_US
) (
    input  wire logic                       CLK,
    input  wire logic                       RESET_N,
    // wishbone slave
    input  wire logic                       CYC_I,
    input  wire logic                       STB_I,
    input  wire logic                       WE_I,
    input  wire logic [7:0]                 ADR_I,
    input  wire logic [3:0]                 SEL_I,
    input  wire logic [31:0]                DAT_I,
    output logic      [31:0]                DAT_O,
    output logic                            ACK_O,
    // monitors and requests
    input  wire logic                       INT_SUPPLY_GOOD,
    input  wire logic                       CORE_REG_GOOD,
    input  wire logic                       POWER_ON_REQUEST,
    input  wire logic                       SYSTEM_POWER_ON,
    input  wire logic                       USB_REGULATOR_ENABLE_PIN,
    input  wire logic                       BOOST_SOFTSTART_DONE,
    input  wire logic                       OVER_TEMPERATURE,
    input  wire logic [pss_pkg::NUM_SW-1:0] SHORT_CIRCUIT,
    input  wire logic [pss_pkg::NUM_SW-1:0] OVERVOLTAGE,
    input  wire logic                       BACKLIGHT_OVERCURRENT,
    // enables
    output logic      [pss_pkg::NUM_SW-1:0] SW_ENABLE,
    output logic      [pss_pkg::NUM_SW-1:0] SW_SWITCH_ALLOW,
    output logic                            CONV_WAKEUP,
    output logic                            CONV_PWM_MODE,
    output logic                            BACKUP_REG_EN,
    output logic                            USB_REG_EN,
    output logic                            DISPLAY_REG_EN,
    output logic                            READY_OUT,
    output logic                            SUBCPU_RESET_OUT
);

    // ----------------------------------------------------------------
    // types and signals
    // ----------------------------------------------------------------
    typedef struct packed {
        pss_pkg::pss_state_e_t             st;
        logic [pss_pkg::CTRL_W-1:0]        ctrl;
        logic [pss_pkg::DIV_W-1:0]         div;
        logic                              tick;
        logic                              req_prev;
        logic                              sys_prev;
        logic                              bl_ovp;
        logic                              therm_seen;
        logic                              short_seen;
        logic [pss_pkg::NUM_SW-1:0]        sw_en;
        logic [pss_pkg::NUM_SW-1:0]        sw_allow;
        logic                              wake;
        logic                              pwm;
        logic                              backup_en;
        logic                              usb_en;
        logic                              disp_en;
        logic                              ready;
        logic                              xrst;
        logic                              ack;
        logic [31:0]                       dat;
    } pss_top_state_t;

    localparam int LIMITS [pss_pkg::NUM_TMR] = '{BACKUP_DELAY_US, USB_DELAY_US,
                                                 SETTLE_DELAY_US, PWM_ENTRY_DELAY_US};

    pss_top_state_t              s_q;
    pss_top_state_t              s_d;
    logic [1:0]                  rst_sync_q;
    logic                        rst_n;
    logic [pss_pkg::NUM_TMR-1:0] tmr_start;
    logic [pss_pkg::NUM_TMR-1:0] tmr_done;

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    // assertion is immediate, release waits two clean edges
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ----------------------------------------------------------------
    // delay timers
    // ----------------------------------------------------------------
    pss_tmr_if tmr [pss_pkg::NUM_TMR] ();

    // one counter per sequencing delay, all paced by the shared tick
    for (genvar g = 0; g < pss_pkg::NUM_TMR; g++) begin : g_tmr
        assign tmr[g].tick  = s_q.tick;
        assign tmr[g].start = tmr_start[g];
        assign tmr_done[g]  = tmr[g].done;
        pss_delay_timer #(
            .W     (pss_pkg::TMR_W),
            .LIMIT (pss_pkg::TMR_W'(LIMITS[g]))
        ) u_tmr (
            .clk   (CLK),
            .rst_n (rst_n),
            .t     (tmr[g])
        );
    end

    // readiness starts the regulator delays, states start the PWM delays
    always_comb begin
        tmr_start[pss_pkg::TMR_BACKUP]    = (s_q.st != pss_pkg::ST_WAKE);
        tmr_start[pss_pkg::TMR_USB]       = (s_q.st != pss_pkg::ST_WAKE);
        tmr_start[pss_pkg::TMR_SETTLE]    = (s_q.st == pss_pkg::ST_SETTLE);
        tmr_start[pss_pkg::TMR_PWM_ENTRY] = (s_q.st == pss_pkg::ST_PWM_ENTRY);
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic                        req_rise;
        logic                        sys_fall;
        logic                        pwm_state;
        logic                        wb_req;
        logic [pss_pkg::NUM_SW-1:0]  run_set;
        logic [31:0]                 stat;
        req_rise  = POWER_ON_REQUEST & ~s_q.req_prev;
        sys_fall  = s_q.sys_prev & ~SYSTEM_POWER_ON;
        pwm_state = 1'b0;
        wb_req    = CYC_I & STB_I & ~s_q.ack;
        run_set   = '0;
        stat      = '0;

        s_d          = s_q;
        s_d.ack      = wb_req;
        s_d.req_prev = POWER_ON_REQUEST;
        s_d.sys_prev = SYSTEM_POWER_ON;

        // microsecond tick divider
        s_d.tick = (s_q.div == pss_pkg::DIV_LAST);
        s_d.div  = s_d.tick ? '0 : s_q.div + pss_pkg::DIV_W'(1);

        // sequence steps
        case (s_q.st)
            pss_pkg::ST_WAKE: begin
                if (INT_SUPPLY_GOOD) s_d.st = pss_pkg::ST_SKIP;
            end
            pss_pkg::ST_SKIP: begin
                if (req_rise) s_d.st = pss_pkg::ST_SETTLE;
            end
            pss_pkg::ST_SETTLE: begin
                if (tmr_done[pss_pkg::TMR_SETTLE]) s_d.st = pss_pkg::ST_PWM_ENTRY;
            end
            pss_pkg::ST_PWM_ENTRY: begin
                if (tmr_done[pss_pkg::TMR_PWM_ENTRY]) s_d.st = pss_pkg::ST_BOOST;
            end
            pss_pkg::ST_BOOST: begin
                if (BOOST_SOFTSTART_DONE) s_d.st = pss_pkg::ST_RUN;
            end
            pss_pkg::ST_RUN: begin
                s_d.st = pss_pkg::ST_RUN;
            end
            pss_pkg::ST_FAULT: begin
                s_d.st = pss_pkg::ST_FAULT;
            end
            default: begin
                s_d.st = pss_pkg::ST_WAKE;
            end
        endcase

        // protection and power-down take priority over sequencing
        pwm_state = (s_q.st != pss_pkg::ST_WAKE) && (s_q.st != pss_pkg::ST_SKIP);
        if (pwm_state && (OVER_TEMPERATURE || (|SHORT_CIRCUIT))) begin
            s_d.st = pss_pkg::ST_FAULT;
        end
        // the far side clears a fault by dropping the request
        if (pwm_state && (!POWER_ON_REQUEST || sys_fall)) begin
            s_d.st = pss_pkg::ST_SKIP;
        end

        // sticky status, a new event beats the request-low clear
        if (!POWER_ON_REQUEST) s_d.bl_ovp = 1'b0;
        if (OVERVOLTAGE[pss_pkg::BACKLIGHT_IDX]) s_d.bl_ovp = 1'b1;
        if (OVER_TEMPERATURE) s_d.therm_seen = 1'b1;
        if (|SHORT_CIRCUIT) s_d.short_seen = 1'b1;

        // register writes, byte lanes honoured
        if (wb_req && WE_I && (ADR_I == pss_pkg::ADDR_CTRL)) begin
            if (SEL_I[0]) s_d.ctrl[7:0] = DAT_I[7:0];
            if (SEL_I[1]) s_d.ctrl[8]   = DAT_I[8];
        end

        // supply loss is the internal logic reset: back to defaults
        if (!INT_SUPPLY_GOOD) begin
            s_d.st         = pss_pkg::ST_WAKE;
            s_d.ctrl       = pss_pkg::CTRL_RESET;
            s_d.bl_ovp     = 1'b0;
            s_d.therm_seen = 1'b0;
            s_d.short_seen = 1'b0;
        end

        // channel enables follow the next state so they switch with it
        if (s_d.st == pss_pkg::ST_RUN) begin
            run_set = s_d.ctrl[pss_pkg::NUM_SW-1:0];
        end else if (s_d.st == pss_pkg::ST_BOOST) begin
            run_set = s_d.ctrl[pss_pkg::NUM_SW-1:0] & pss_pkg::BOOST_MASK;
        end
        if (s_d.bl_ovp) run_set[pss_pkg::BACKLIGHT_IDX] = 1'b0;
        s_d.sw_en    = run_set;
        s_d.sw_allow = ~OVERVOLTAGE;
        if (BACKLIGHT_OVERCURRENT) s_d.sw_allow[pss_pkg::BACKLIGHT_IDX] = 1'b0;

        // converter mode and regulator enables
        s_d.wake      = (s_d.st == pss_pkg::ST_WAKE);
        s_d.pwm       = (s_d.st != pss_pkg::ST_WAKE) && (s_d.st != pss_pkg::ST_SKIP);
        s_d.backup_en = tmr_done[pss_pkg::TMR_BACKUP] && (s_d.st != pss_pkg::ST_WAKE)
                        && s_d.ctrl[pss_pkg::CTRL_BACKUP_BIT];
        s_d.usb_en    = tmr_done[pss_pkg::TMR_USB] && (s_d.st != pss_pkg::ST_WAKE)
                        && USB_REGULATOR_ENABLE_PIN;
        s_d.disp_en   = (s_d.st == pss_pkg::ST_RUN)
                        && s_d.ctrl[pss_pkg::CTRL_DISPLAY_BIT];
        s_d.ready     = INT_SUPPLY_GOOD;
        s_d.xrst      = CORE_REG_GOOD;

        // status word
        stat[pss_pkg::STAT_STATE_LSB +: 7] = s_q.st;
        stat[pss_pkg::STAT_READY]          = s_q.ready;
        stat[pss_pkg::STAT_XRST]           = s_q.xrst;
        stat[pss_pkg::STAT_BL_OVP]         = s_q.bl_ovp;
        stat[pss_pkg::STAT_THERM]          = s_q.therm_seen;
        stat[pss_pkg::STAT_SHORT]          = s_q.short_seen;
        stat[pss_pkg::STAT_SS_DONE]        = BOOST_SOFTSTART_DONE;
        stat[pss_pkg::STAT_PWM]            = s_q.pwm;

        // read data, unmapped addresses read zero
        s_d.dat = '0;
        if (wb_req && !WE_I) begin
            if (ADR_I == pss_pkg::ADDR_CTRL) begin
                s_d.dat = {23'h0, s_q.ctrl};
            end else if (ADR_I == pss_pkg::ADDR_STATUS) begin
                s_d.dat = stat;
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            s_q      <= '0;
            s_q.st   <= pss_pkg::ST_WAKE;
            s_q.ctrl <= pss_pkg::CTRL_RESET;
            s_q.wake <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all straight from flops
    // ----------------------------------------------------------------
    assign DAT_O            = s_q.dat;
    assign ACK_O            = s_q.ack;
    assign SW_ENABLE        = s_q.sw_en;
    assign SW_SWITCH_ALLOW  = s_q.sw_allow;
    assign CONV_WAKEUP      = s_q.wake;
    assign CONV_PWM_MODE    = s_q.pwm;
    assign BACKUP_REG_EN    = s_q.backup_en;
    assign USB_REG_EN       = s_q.usb_en;
    assign DISPLAY_REG_EN   = s_q.disp_en;
    assign READY_OUT        = s_q.ready;
    assign SUBCPU_RESET_OUT = s_q.xrst;

endmodule

// ==== rtl/pss_pkg.sv ====
// Purpose: shared constants and types for the power sequencer and protection block
// Assumes: 100 MHz system clock, classic Wishbone register access
// Notes:   delays are counted in 1 us ticks from a clock divider

package pss_pkg;

    // ----------------------------------------------------------------
    // clock and tick
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS       = 1000;
    localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
    localparam int DIV_W         = 7;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

    // ----------------------------------------------------------------
    // sequencing delays, in microseconds
    // ----------------------------------------------------------------
    localparam int BACKUP_DELAY_US    = 30;
    localparam int USB_DELAY_US       = 1030;
    localparam int SETTLE_DELAY_US    = 60;
    localparam int PWM_ENTRY_DELAY_US = 1000;
    localparam int TMR_W              = 11;
    localparam int NUM_TMR            = 4;
    localparam int TMR_BACKUP         = 0;
    localparam int TMR_USB            = 1;
    localparam int TMR_SETTLE         = 2;
    localparam int TMR_PWM_ENTRY      = 3;

    // ----------------------------------------------------------------
    // switching channels, index 0 is channel one
    // ----------------------------------------------------------------
    localparam int NUM_SW        = 7;
    localparam int BOOST_IDX     = 2;
    localparam int BACKLIGHT_IDX = 5;
    localparam logic [NUM_SW-1:0] BOOST_MASK = 7'h04;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam int CTRL_W           = 9;
    localparam int CTRL_BACKUP_BIT  = 7;
    localparam int CTRL_DISPLAY_BIT = 8;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h1FF;
    localparam int STAT_STATE_LSB   = 0;
    localparam int STAT_READY       = 7;
    localparam int STAT_XRST        = 8;
    localparam int STAT_BL_OVP      = 9;
    localparam int STAT_THERM       = 10;
    localparam int STAT_SHORT       = 11;
    localparam int STAT_SS_DONE     = 12;
    localparam int STAT_PWM         = 13;

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_WAKE      = 7'h01,
        ST_SKIP      = 7'h02,
        ST_SETTLE    = 7'h04,
        ST_PWM_ENTRY = 7'h08,
        ST_BOOST     = 7'h10,
        ST_RUN       = 7'h20,
        ST_FAULT     = 7'h40
    } pss_state_e_t;

endpackage

// ==== rtl/pss_tmr_if.sv ====
// Purpose: handshake between the sequencer and one delay timer
// Assumes: tick is a one-cycle enable every microsecond
// Notes:   done is a level that holds while start stays high

interface pss_tmr_if;
    logic tick;
    logic start;
    logic done;

    modport timer (input tick, input start, output done);
    modport ctrl  (output tick, output start, input done);
endinterface

// ==== rtl/pss_delay_timer.sv ====
// Purpose: microsecond delay counter
// Assumes: start is held high for the whole wait
// Notes:   counts LIMIT+1 ticks so the wait is never short of LIMIT us

module pss_delay_timer #(
    parameter int           W     = 11,
    parameter logic [W-1:0] LIMIT = '0
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    pss_tmr_if.timer        t
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         done;
    } pss_tmr_state_t;

    pss_tmr_state_t s_q;
    pss_tmr_state_t s_d;

    // ----------------------------------------------------------------
    // counting
    // ----------------------------------------------------------------
    // dropping start restarts the wait from zero
    always_comb begin
        s_d = s_q;
        if (!t.start) begin
            s_d = '0;
        end else if (t.tick && !s_q.done) begin
            if (s_q.cnt == LIMIT) begin
                s_d.done = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign t.done = s_q.done;

endmodule

// ==== verif/pss_sequencer_assertions.sv ====
// Purpose: concurrent checks on the sequencer top ports
// Assumes: one clock domain, bus requests only after the reset sync has lifted
// Notes:   delay floors scale with the parameters handed on by the bind
module pss_sequencer_assertions #(
    parameter int BACKUP_DELAY_US = 30, USB_DELAY_US = 1030, SETTLE_DELAY_US = 60, PWM_ENTRY_DELAY_US = 1000
) (
    input wire logic       CLK,
    input wire logic       RESET_N,
    input wire logic       CYC_I,
    input wire logic       STB_I,
    input wire logic       ACK_O,
    input wire logic       INT_SUPPLY_GOOD,
    input wire logic       CORE_REG_GOOD,
    input wire logic       SYSTEM_POWER_ON,
    input wire logic       USB_REGULATOR_ENABLE_PIN,
    input wire logic       OVER_TEMPERATURE,
    input wire logic [6:0] SHORT_CIRCUIT,
    input wire logic [6:0] OVERVOLTAGE,
    input wire logic       BACKLIGHT_OVERCURRENT,
    input wire logic [6:0] SW_ENABLE,
    input wire logic [6:0] SW_SWITCH_ALLOW,
    input wire logic       CONV_WAKEUP,
    input wire logic       CONV_PWM_MODE,
    input wire logic       USB_REG_EN,
    input wire logic       DISPLAY_REG_EN,
    input wire logic       BACKUP_REG_EN,
    input wire logic       READY_OUT,
    input wire logic       SUBCPU_RESET_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    int rdy_q;
    int pwm_q;
    // cycles since readiness and since pwm entry; delay floors are measured on these
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdy_q <= 0;
            pwm_q <= 0;
        end else begin
            rdy_q <= READY_OUT ? rdy_q + 1 : 0;
            pwm_q <= CONV_PWM_MODE ? pwm_q + 1 : 0;
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    property p_ack; CYC_I && STB_I && !ACK_O |=> ACK_O ##1 !ACK_O; endproperty
    a_ack: assert property (p_ack) else $error("bus ack not a one cycle pulse");
    property p_wake; !INT_SUPPLY_GOOD |-> ##[1:2] (CONV_WAKEUP && !READY_OUT && SW_ENABLE == 7'h00); endproperty
    a_wake: assert property (p_wake) else $error("supply loss did not return to wake");
    property p_xrst; !CORE_REG_GOOD |=> !SUBCPU_RESET_OUT; endproperty
    a_xrst: assert property (p_xrst) else $error("reset out released without core good");
    property p_ovp; OVERVOLTAGE[1] |=> !SW_SWITCH_ALLOW[1]; endproperty
    a_ovp: assert property (p_ovp) else $error("switching allowed in overvoltage");
    property p_ocp; BACKLIGHT_OVERCURRENT |=> !SW_SWITCH_ALLOW[5]; endproperty
    a_ocp: assert property (p_ocp) else $error("backlight switching in overcurrent");
    property p_therm; OVER_TEMPERATURE && CONV_PWM_MODE |-> ##[1:2] (SW_ENABLE == 7'h00 && !DISPLAY_REG_EN); endproperty
    a_therm: assert property (p_therm) else $error("channels still on after thermal fault");
    property p_short; |SHORT_CIRCUIT && CONV_PWM_MODE |-> ##[1:2] (SW_ENABLE == 7'h00 && !DISPLAY_REG_EN); endproperty
    a_short: assert property (p_short) else $error("channels still on after short");
    property p_sysoff; $fell(SYSTEM_POWER_ON) && CONV_PWM_MODE |-> ##[1:2] (SW_ENABLE == 7'h00 && !CONV_PWM_MODE); endproperty
    a_sysoff: assert property (p_sysoff) else $error("channels on after system power off");
    property p_bk; $rose(BACKUP_REG_EN) |-> rdy_q >= BACKUP_DELAY_US * pss_pkg::TICK_CYCLES; endproperty
    a_bk: assert property (p_bk) else $error("backup regulator on too early");
    property p_usb; $rose(USB_REG_EN) |-> rdy_q >= USB_DELAY_US * pss_pkg::TICK_CYCLES && $past(USB_REGULATOR_ENABLE_PIN); endproperty
    a_usb: assert property (p_usb) else $error("usb regulator on early or pin low");
    property p_boost; $rose(SW_ENABLE[2]) |-> pwm_q >= (SETTLE_DELAY_US + PWM_ENTRY_DELAY_US) * pss_pkg::TICK_CYCLES; endproperty
    a_boost: assert property (p_boost) else $error("boost started before pwm delays");
endmodule

bind pss_sequencer pss_sequencer_assertions #(.BACKUP_DELAY_US(BACKUP_DELAY_US), .USB_DELAY_US(USB_DELAY_US),
    .SETTLE_DELAY_US(SETTLE_DELAY_US), .PWM_ENTRY_DELAY_US(PWM_ENTRY_DELAY_US)) i_chk (.CLK(CLK), .RESET_N(RESET_N),
    .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O), .INT_SUPPLY_GOOD(INT_SUPPLY_GOOD), .CORE_REG_GOOD(CORE_REG_GOOD),
    .SYSTEM_POWER_ON(SYSTEM_POWER_ON), .USB_REGULATOR_ENABLE_PIN(USB_REGULATOR_ENABLE_PIN),
    .OVER_TEMPERATURE(OVER_TEMPERATURE), .SHORT_CIRCUIT(SHORT_CIRCUIT), .OVERVOLTAGE(OVERVOLTAGE),
    .BACKLIGHT_OVERCURRENT(BACKLIGHT_OVERCURRENT), .SW_ENABLE(SW_ENABLE), .SW_SWITCH_ALLOW(SW_SWITCH_ALLOW),
    .CONV_WAKEUP(CONV_WAKEUP), .CONV_PWM_MODE(CONV_PWM_MODE), .USB_REG_EN(USB_REG_EN),
    .DISPLAY_REG_EN(DISPLAY_REG_EN), .BACKUP_REG_EN(BACKUP_REG_EN), .READY_OUT(READY_OUT),
    .SUBCPU_RESET_OUT(SUBCPU_RESET_OUT));

// ==== verif/pss_subcpu_model.sv ====
// Purpose: sub-processor side of the power-on handshake
// Assumes: the bench says when software wants the system up
// Notes:   registers are written by the bench between runs, and once mid-run by the protection checks
module pss_subcpu_model (
    input  wire logic clk,
    input  wire logic go,
    input  wire logic reset_released,
    output logic      power_on_request
);
    timeunit 1ns;
    timeprecision 1ps;
    initial power_on_request = 1'b0;
    // never request while held in reset; dropped on command after a fault to get back to skip
    always @(posedge clk) power_on_request <= go && reset_released;
endmodule

// ==== verif/pss_sequencer_tb_top.sv ====
// Purpose: self-checking bench for the power sequencer
// Assumes: shortened delays 2/4/3/5 us
// Notes:   runs cover thermal, short and system power-off faults
module pss_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, cyc, stb, we, sup, core, spo, pin, ss, ot, oc, go, req, ack, pwm, wake, bk_en, usb_en, dsp_en;
    logic rdy, xr;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, dat_o;
    logic [6:0] sc, ov, sw_en, allow;
    int errors, total_checks, cycles;
    pss_sequencer #(.BACKUP_DELAY_US(2), .USB_DELAY_US(4), .SETTLE_DELAY_US(3), .PWM_ENTRY_DELAY_US(5)) i_dut (
        .CLK(clk), .RESET_N(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'h3), .DAT_I(wdat),
        .DAT_O(dat_o), .ACK_O(ack), .INT_SUPPLY_GOOD(sup), .CORE_REG_GOOD(core), .POWER_ON_REQUEST(req),
        .SYSTEM_POWER_ON(spo), .USB_REGULATOR_ENABLE_PIN(pin), .BOOST_SOFTSTART_DONE(ss), .OVER_TEMPERATURE(ot),
        .SHORT_CIRCUIT(sc), .OVERVOLTAGE(ov), .BACKLIGHT_OVERCURRENT(oc), .SW_ENABLE(sw_en), .SW_SWITCH_ALLOW(allow),
        .CONV_WAKEUP(wake), .CONV_PWM_MODE(pwm), .BACKUP_REG_EN(bk_en), .USB_REG_EN(usb_en),
        .DISPLAY_REG_EN(dsp_en), .READY_OUT(rdy), .SUBCPU_RESET_OUT(xr));
    pss_subcpu_model i_cpu (.clk(clk), .go(go), .reset_released(xr), .power_on_request(req));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask
    // classic cycle: request held until ack is sampled, then released for at least a cycle
    // no local limit: a missing ack is caught by the hang guard and ends in the verdict
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
        do @(posedge clk); while (ack !== 1'b1);
        rdat = dat_o;
        {cyc, stb} <= 2'b00;
    endtask
    // bounded wait, since the timer phase makes the exact cycle loose
    task automatic wsw(input logic [6:0] e);
        int n;
        n = 0;
        while (sw_en !== e && n < 2000) begin @(posedge clk); n++; end
        chk("sw_en", 32'(sw_en), 32'(e));
    endtask
    task automatic prot;
        ov <= 7'h02; repeat (2) @(posedge clk); chk("ovp", 32'(allow), 32'h7D);
        ov <= 7'h00; repeat (2) @(posedge clk); chk("ovp_end", 32'(allow), 32'h7F);
        oc <= 1'b1; repeat (2) @(posedge clk); chk("ocp", 32'(allow), 32'h5F);
        oc <= 1'b0; repeat (2) @(posedge clk); chk("ocp_end", 32'(allow), 32'h7F);
        ov <= 7'h20; repeat (2) @(posedge clk); ov <= 7'h00; repeat (3) @(posedge clk);
        chk("bl_latch", 32'(sw_en), 32'h5E);
        wb(1'b1, 8'h00, 32'h07C); repeat (2) @(posedge clk);
        chk("sw_off", 32'(sw_en), 32'h5C);
        chk("bk_off", 32'(bk_en), 0);
    endtask
    // one power-on run ending in fault k: 0 thermal, 1 short, 2 system power-off
    task automatic run(input int k, input logic [8:0] c);
        go <= 1'b1; repeat (3) @(posedge clk);
        chk("pwm_on", 32'(pwm), 1);
        chk("early", 32'(sw_en), 0);
        wsw({4'h0, c[2], 2'b00});
        chk("dsp_boost", 32'(dsp_en), 0);
        ss <= 1'b1;
        wsw(c[6:0]);
        chk("dsp_run", 32'(dsp_en), 32'(c[8]));
        if (k == 2) prot();
        case (k)
            0: ot <= 1'b1;
            1: sc <= 7'h08;
            default: spo <= 1'b0;
        endcase
        repeat (3) @(posedge clk);
        chk("fault_sw", 32'(sw_en), 0);
        chk("fault_dsp", 32'(dsp_en), 0);
        {ot, sc, go, ss} <= '0; repeat (4) @(posedge clk);
        chk("skip", 32'(pwm), 0);
        spo <= 1'b1;
        $display("run %0d done", k);
    endtask
    initial begin clk = 1'b0; forever #5 clk = ~clk; end
    // hang guard, well above the expected run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin errors++; give_verdict(); end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n, cyc, stb, we, sup, core, pin, ss, ot, oc, go, sc, ov, adr, wdat} = '0;
        spo = 1'b1;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1; repeat (4) @(posedge clk);
        wb(1'b0, 8'h00, 0); chk("ctrl_rst", rdat, 32'h1FF);
        wb(1'b0, 8'h04, 0); chk("state_wake", rdat & 32'h7F, 32'h01);
        sup <= 1'b1; repeat (3) @(posedge clk);
        chk("ready", 32'(rdy), 1);
        chk("wake_off", 32'(wake), 0);
        chk("bk_early", 32'(bk_en), 0);
        core <= 1'b1; pin <= 1'b1; repeat (347) @(posedge clk);
        chk("subcpu_reset_out", 32'(xr), 1);
        chk("usb_early", 32'(usb_en), 0);
        repeat (500) @(posedge clk);
        chk("bk_on", 32'(bk_en), 1);
        chk("usb_on", 32'(usb_en), 1);
        pin <= 1'b0; repeat (3) @(posedge clk); chk("usb_pin", 32'(usb_en), 0);
        pin <= 1'b1;
        $display("startup done");
        run(0, 9'h1FF);
        wb(1'b1, 8'h00, 32'h0FE); wb(1'b1, 8'h04, 32'hFFFF); wb(1'b0, 8'h00, 0);
        chk("ctrl_rw", rdat, 32'h0FE);
        wb(1'b0, 8'h08, 0); chk("unmapped", rdat, 0);
        run(1, 9'h0FE);
        run(2, 9'h0FE);
        wb(1'b0, 8'h04, 0); chk("sticky", (rdat >> 9) & 32'h7, 32'h6);
        sup <= 1'b0; repeat (3) @(posedge clk);
        chk("supply_loss", 32'({wake, rdy}), 32'h2);
        sup <= 1'b1; repeat (4) @(posedge clk);
        wb(1'b0, 8'h00, 0); chk("ctrl_clr", rdat, 32'h1FF);
        wb(1'b0, 8'h04, 0); chk("sticky_clr", (rdat >> 9) & 32'h7, 0);
        $display("supply loss done");
        give_verdict();
    end
endmodule
